// *** design/gpcs_pkg.sv ***
/*
 Shared constants and carrier types of the 8b/10b coding sublayer:
 register offsets, reset values, code tables and packed structs.
 Assumes a single system clock shared by the registers and user logic.
*/
package gpcs_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PAT0 = 8'h04;
	localparam logic [7:0] A_PAT1 = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [8:0] CTRL_RST = 9'h1B8;
	localparam logic [9:0] PAT0_RST = 10'h0FA;
	localparam logic [9:0] PAT1_RST = 10'h305;
	localparam int B_FIFO_BYP = 0;
	localparam int B_ENC_BYP = 1;
	localparam int B_DEC_BYP = 2;
	localparam int B_ALIGN = 3;
	localparam int B_CPLUS = 4;
	localparam int B_CMINUS = 5;
	localparam int B_CDEF = 6;
	localparam int B_PAT0 = 7;
	localparam int B_PAT1 = 8;

	// ----------------------------------------------------------------
	// Coding constants
	// ----------------------------------------------------------------
	localparam logic [6:0] COMMA_P = 7'h1F;
	localparam logic [6:0] COMMA_M = 7'h60;
	localparam logic [5:0] K28_6B = 6'h0F;
	localparam logic [3:0] ALT7_4B = 4'h7;
	localparam logic [3:0] CNT_LAST = 4'h9;
	localparam int TXD = 4;
	localparam int RXD = 4;
	localparam logic [2:0] RX_SKIP_LVL = 3'h3;
	localparam logic [2:0] RX_CENTER = 3'h2;
	localparam logic [5:0] ENC6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] ENC4 [8] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TX_HI = 2'b01, TX_LO = 2'b10} gpcs_ph_t;
	typedef struct packed {
		logic mode;
		logic val;
		logic k;
		logic [7:0] data;
	} gpcs_tx_lane_t;
	typedef struct packed {
		gpcs_tx_lane_t hi;
		gpcs_tx_lane_t lo;
	} gpcs_tx_word_t;
	typedef struct packed {
		logic k;
		logic rd;
		logic derr;
		logic oerr;
		logic comma;
		logic [7:0] data;
	} gpcs_rx_char_t;
	typedef struct packed {
		logic rd;
		logic [9:0] code;
	} gpcs_enc_t;
	typedef struct packed {
		logic ok;
		logic any;
		logic k;
		logic [7:0] data;
	} gpcs_dec_t;
endpackage

// *** design/gpcs_top.sv ***
/*
 8b/10b coding sublayer: four-word TX FIFO, encoder with disparity
 forcing, RX word aligner, decoder, elastic buffer and APB registers.
 Assumes user logic runs on clk_sys_i; link clocks and the RX serial
 bit are asynchronous and are sampled here.
*/
// Contract
// - Encoder running disparity starts negative after reset.
// - Encoder running disparity is always visible on an output.
// - Per-byte mode and value bits force or invert disparity.
// - Four-entry TX FIFO reports overflow and underflow.
// - TX FIFO can be bypassed by a configuration bit.
// - Encoder turns 8 data bits plus K flag into 10 bits.
// - K flag selects control characters, else data characters.
// - K flag with an invalid control byte raises an error.
// - Encoder bypass sends raw 10-bit characters.
// - Most significant byte of a word is sent first.
// - Decoder bypass delivers raw 10-bit characters.
// - Raw bits map first to K flag, then disparity, then data.
// - Valid code with wrong disparity flags a disparity error.
// - Code not in the table flags an out-of-table error.
// - RX disparity is tracked for all codes and shown.
// - Out-of-table codes pass through unmodified with the error; rd carries the running disparity, not raw bit 8.
// - Valid control characters raise the K indication.
// - Comma detect: any or defined commas, two polarities each.
// - Each RX byte lane carries all its own indicators.
// - Elastic buffer read pointer does clock correction and bonding.
// - Up to two programmed characters align the word boundary.
// - Comma on the current boundary leaves alignment unchanged.
// - TX and RX have separate synchronous resets.
module gpcs_top import gpcs_pkg::*; (
	input logic clk_sys_i,
	input logic resetn_i,
	input logic ce_i,
	input logic psel_i,
	input logic penable_i,
	input logic pwrite_i,
	input logic [7:0] paddr_i,
	input logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input logic tx_reset_i,
	input logic tx_valid_i,
	input gpcs_tx_word_t tx_word_i,
	output logic tx_ready_o,
	output logic tx_overflow_o,
	output logic tx_underflow_o,
	output logic tx_control_char_error_o,
	output logic tx_running_disparity_o,
	input logic tx_link_clk_i,
	output logic [9:0] tx_code_o,
	output logic tx_code_stb_o,
	input logic rx_reset_i,
	input logic rx_link_clk_i,
	input logic rx_bit_i,
	input logic rx_bond_i,
	output gpcs_rx_char_t rx_char_o,
	output logic rx_valid_o,
	input logic rx_ready_i,
	output logic rx_realign_o,
	output logic rx_running_disparity_o
);
	// ----------------------------------------------------------------
	// Coding functions
	// ----------------------------------------------------------------
	function automatic logic kvalid(input logic [7:0] d);
		return d[4:0] == 5'd28 || d inside {8'hF7, 8'hFB, 8'hFD, 8'hFE};
	endfunction

	function automatic gpcs_enc_t enc8b10b(input logic [7:0] d,
		input logic k, input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic rm;
		logic alt;
		c6 = (k && d[4:0] == 5'd28) ? K28_6B : ENC6[d[4:0]];
		if (rd && ($countones(c6) != 3 || d[4:0] == 5'd7))
			c6 = ~c6;
		rm = ($countones(c6) == 3) ? rd : !rd;
		// Alternate x.7 avoids a run of five equal bits
		alt = d[7:5] == 3'd7 && (k
			|| (!rm && d[4:0] inside {5'd17, 5'd18, 5'd20})
			|| (rm && d[4:0] inside {5'd11, 5'd13, 5'd14}));
		c4 = alt ? ALT7_4B : ENC4[d[7:5]];
		if ($countones(c4) != 2 || d[7:5] == 3'd3)
			c4 = rm ? ~c4 : c4;
		else if (k && d[4:0] == 5'd28 && !rm)
			c4 = ~c4;
		return '{rd: ($countones(c4) == 2) ? rm : !rm, code: {c6, c4}};
	endfunction

	// Search by re-encoding: small source, large but plain logic
	function automatic gpcs_dec_t dec8b10b(input logic [9:0] c,
		input logic rd);
		gpcs_enc_t e;
		gpcs_dec_t r;
		r = '0;
		for (int v = 0; v < 1024; v++) begin
			e = enc8b10b(v[7:0], v[8], v[9]);
			if (e.code == c && (!v[8] || kvalid(v[7:0]))) begin
				r.any = 1'b1;
				r.k = v[8];
				r.data = v[7:0];
				if (v[9] == rd)
					r.ok = 1'b1;
			end
		end
		return r;
	endfunction

	function automatic logic rd_after(input logic [9:0] c, input logic rd);
		logic r;
		r = rd;
		if ($countones(c[9:4]) != 3)
			r = $countones(c[9:4]) > 3;
		if ($countones(c[3:0]) != 2)
			r = $countones(c[3:0]) > 2;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Reset release and input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_ff;
	logic rst_n;
	logic [2:0] txc_ff, rxc_ff, rxb_ff;
	logic txl_ff, rxl_ff, rxbl_ff;
	logic tx_edge, rx_edge;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			rst_ff <= 2'b00;
		else
			rst_ff <= {rst_ff[0], 1'b1};
	end
	assign rst_n = rst_ff[1];

	// Link clock only sampled; frequency lock keeps edges seen
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			txc_ff <= '0;
			rxc_ff <= '0;
			rxb_ff <= '0;
			txl_ff <= 1'b0;
			rxl_ff <= 1'b0;
			rxbl_ff <= 1'b0;
		end else if (ce_i) begin
			txc_ff <= {txc_ff[1:0], tx_link_clk_i};
			rxc_ff <= {rxc_ff[1:0], rx_link_clk_i};
			rxb_ff <= {rxb_ff[1:0], rx_bit_i};
			if (txc_ff[1] == txc_ff[2])
				txl_ff <= txc_ff[2];
			if (rxc_ff[1] == rxc_ff[2])
				rxl_ff <= rxc_ff[2];
			if (rxb_ff[1] == rxb_ff[2])
				rxbl_ff <= rxb_ff[2];
		end
	end
	assign tx_edge = ce_i && txc_ff[1] && txc_ff[2] && !txl_ff;
	assign rx_edge = ce_i && rxc_ff[1] && rxc_ff[2] && !rxl_ff;

	// ----------------------------------------------------------------
	// APB registers
	// ----------------------------------------------------------------
	logic [8:0] ctrl_ff;
	logic [9:0] pat0_ff, pat1_ff;
	logic wr_en, fifo_byp, enc_byp, dec_byp;
	logic [2:0] tcnt, rcnt;
	logic trd_ff, rrd_ff;

	assign wr_en = psel_i && penable_i && pwrite_i && ce_i;
	assign fifo_byp = ctrl_ff[B_FIFO_BYP];
	assign enc_byp = ctrl_ff[B_ENC_BYP];
	assign dec_byp = ctrl_ff[B_DEC_BYP];
	assign pready_o = ce_i;
	assign pslverr_o = psel_i && penable_i
		&& !(paddr_i inside {A_CTRL, A_PAT0, A_PAT1, A_STAT});

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= CTRL_RST;
			pat0_ff <= PAT0_RST;
			pat1_ff <= PAT1_RST;
		end else if (wr_en) begin
			if (paddr_i == A_CTRL)
				ctrl_ff <= pwdata_i[8:0];
			if (paddr_i == A_PAT0)
				pat0_ff <= pwdata_i[9:0];
			if (paddr_i == A_PAT1)
				pat1_ff <= pwdata_i[9:0];
		end
	end

	always_comb begin
		prdata_o = '0;
		unique case (paddr_i)
			A_CTRL: prdata_o[8:0] = ctrl_ff;
			A_PAT0: prdata_o[9:0] = pat0_ff;
			A_PAT1: prdata_o[9:0] = pat1_ff;
			A_STAT: prdata_o[7:0] = {rcnt, tcnt, rrd_ff, trd_ff};
			default: prdata_o = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// Transmit FIFO and encoder
	// ----------------------------------------------------------------
	gpcs_tx_word_t txm [TXD];
	gpcs_tx_word_t src;
	gpcs_tx_lane_t lo_ff, lane;
	gpcs_ph_t ph_ff;
	gpcs_enc_t enc;
	logic [2:0] twp_ff, trp_ff;
	logic [9:0] tcode_ff;
	logic tfull, need, have, push, pop, emit, rd_in;
	logic tstb_ff, kerr_ff, tovf_ff, tunf_ff;

	assign tcnt = twp_ff - trp_ff;
	assign tfull = tcnt == 3'(TXD);
	assign need = tx_edge && ph_ff == TX_HI;
	assign have = fifo_byp ? tx_valid_i : tcnt != 3'd0;
	assign push = ce_i && !fifo_byp && tx_valid_i && !tfull;
	assign pop = need && have;
	assign emit = pop || (tx_edge && ph_ff == TX_LO);
	assign src = fifo_byp ? tx_word_i : txm[trp_ff[1:0]];
	assign tx_ready_o = fifo_byp ? need : ce_i && !tfull;
	// Upper byte goes out first, lower byte on the next link edge
	assign lane = (ph_ff == TX_HI) ? src.hi : lo_ff;
	// Mode forces the value, otherwise value inverts the state
	assign rd_in = lane.mode ? lane.val : (trd_ff ^ lane.val);
	assign enc = enc8b10b(lane.data, lane.k, rd_in);

	always_ff @(posedge clk_sys_i) begin
		if (push && !tx_reset_i)
			txm[twp_ff[1:0]] <= tx_word_i;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			twp_ff <= '0;
			trp_ff <= '0;
			tovf_ff <= 1'b0;
			tunf_ff <= 1'b0;
		end else if (ce_i) begin
			tovf_ff <= !tx_reset_i && !fifo_byp && tx_valid_i && tfull;
			tunf_ff <= !tx_reset_i && need && !have;
			if (tx_reset_i) begin
				twp_ff <= '0;
				trp_ff <= '0;
			end else begin
				if (push)
					twp_ff <= twp_ff + 3'd1;
				if (pop && !fifo_byp)
					trp_ff <= trp_ff + 3'd1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ph_ff <= TX_HI;
			lo_ff <= '0;
			trd_ff <= 1'b0;
			tcode_ff <= '0;
			tstb_ff <= 1'b0;
			kerr_ff <= 1'b0;
		end else if (ce_i) begin
			tstb_ff <= emit && !tx_reset_i;
			if (tx_reset_i) begin
				ph_ff <= TX_HI;
				lo_ff <= '0;
				trd_ff <= 1'b0;
				kerr_ff <= 1'b0;
			end else if (emit) begin
				ph_ff <= (ph_ff == TX_HI) ? TX_LO : TX_HI;
				if (ph_ff == TX_HI)
					lo_ff <= src.lo;
				if (enc_byp) begin
					tcode_ff <= {lane.mode, lane.val, lane.data};
				end else begin
					tcode_ff <= enc.code;
					trd_ff <= enc.rd;
				end
				kerr_ff <= !enc_byp && lane.k && !kvalid(lane.data);
			end
		end
	end
	assign tx_code_o = tcode_ff;
	assign tx_code_stb_o = tstb_ff;
	assign tx_running_disparity_o = trd_ff;
	assign tx_control_char_error_o = kerr_ff;
	assign tx_overflow_o = tovf_ff;
	assign tx_underflow_o = tunf_ff;

	// ----------------------------------------------------------------
	// Receive aligner, decoder and elastic buffer
	// ----------------------------------------------------------------
	gpcs_rx_char_t rxm [RXD];
	gpcs_rx_char_t rin;
	gpcs_dec_t dr;
	logic [9:0] sh_ff, win;
	logic [3:0] cnt_ff;
	logic [2:0] rwp_ff, rrp_ff;
	logic match, cstb, cp, cm, skip, realign_ff;

	// Window holds the latest ten bits, first received bit in bit 9
	assign win = {sh_ff[8:0], rxbl_ff};
	assign match = ctrl_ff[B_ALIGN]
		&& ((ctrl_ff[B_PAT0] && win == pat0_ff)
		|| (ctrl_ff[B_PAT1] && win == pat1_ff));
	assign cstb = rx_edge && (match || cnt_ff == CNT_LAST);

	always_comb begin
		dr = dec8b10b(win, rrd_ff);
		cp = win[9:3] == COMMA_P;
		cm = win[9:3] == COMMA_M;
		if (ctrl_ff[B_CDEF]) begin
			cp = cp && dr.any && dr.k && dr.data inside {8'h3C, 8'hBC, 8'hFC};
			cm = cm && dr.any && dr.k && dr.data inside {8'h3C, 8'hBC, 8'hFC};
		end
		// Per-lane indicators travel together
		rin.comma = (cp && ctrl_ff[B_CPLUS]) || (cm && ctrl_ff[B_CMINUS]);
		rin.rd = rd_after(win, rrd_ff);
		if (dec_byp || !dr.any) begin
			rin.k = win[9];
			rin.rd = dec_byp ? win[8] : rin.rd;
			rin.data = win[7:0];
		end else begin
			rin.k = dr.k;
			rin.data = dr.data;
		end
		rin.derr = !dec_byp && dr.any && !dr.ok;
		rin.oerr = !dec_byp && !dr.any;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			sh_ff <= '0;
			cnt_ff <= '0;
			rrd_ff <= 1'b0;
			realign_ff <= 1'b0;
		end else if (ce_i) begin
			realign_ff <= !rx_reset_i && rx_edge && match
				&& cnt_ff != CNT_LAST;
			if (rx_reset_i) begin
				sh_ff <= '0;
				cnt_ff <= '0;
				rrd_ff <= 1'b0;
			end else if (rx_edge) begin
				sh_ff <= win;
				cnt_ff <= cstb ? 4'd0 : cnt_ff + 4'd1;
				if (cstb)
					rrd_ff <= rd_after(win, rrd_ff);
			end
		end
	end

	assign rcnt = rwp_ff - rrp_ff;
	// Clock correction drops a comma only while the buffer holds three or more characters
	assign skip = rcnt >= RX_SKIP_LVL && rxm[rrp_ff[1:0]].comma
		&& rxm[rrp_ff[1:0]].k;
	assign rx_valid_o = ce_i && rcnt != 3'd0 && !skip;
	assign rx_char_o = rxm[rrp_ff[1:0]];
	assign rx_running_disparity_o = rrd_ff;
	assign rx_realign_o = realign_ff;

	always_ff @(posedge clk_sys_i) begin
		if (ce_i && !rx_reset_i && cstb && rcnt != 3'(RXD))
			rxm[rwp_ff[1:0]] <= rin;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rwp_ff <= '0;
			rrp_ff <= '0;
		end else if (ce_i) begin
			if (rx_reset_i) begin
				rwp_ff <= '0;
				rrp_ff <= '0;
			end else begin
				if (cstb && rcnt != 3'(RXD))
					rwp_ff <= rwp_ff + 3'd1;
				if (rx_bond_i && rcnt > RX_CENTER)
					rrp_ff <= rwp_ff - RX_CENTER;
				else if (skip || (rx_valid_o && rx_ready_i))
					rrp_ff <= rrp_ff + 3'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n);

	a_txrd_init: assert property (ce_i && tx_reset_i |=>
		!tx_running_disparity_o) else $error("tx disparity not negative");
	a_txrd_hold: assert property (!tx_code_stb_o && !$past(tx_reset_i)
		|-> $stable(tx_running_disparity_o)) else $error("tx rd moved");
	a_force_disp: assert property (emit && !tx_reset_i && !enc_byp
		&& lane.mode |=> tx_running_disparity_o
		== rd_after(tx_code_o, $past(lane.val))) else $error("force lost");
	a_fifo_bound: assert property (tcnt <= 3'(TXD))
		else $error("tx fifo count too large");
	a_ovf_flag: assert property (ce_i && !tx_reset_i && !fifo_byp
		&& tx_valid_i && tfull |=> tx_overflow_o) else $error("no overflow");
	a_kerr_flag: assert property (emit && !tx_reset_i && !enc_byp
		&& lane.k && !kvalid(lane.data) |=> tx_control_char_error_o)
		else $error("no control char error");
	a_msb_first: assert property (pop && !tx_reset_i && enc_byp
		|=> tx_code_o[7:0] == $past(src.hi.data)) else $error("lsb first");
	a_oerr_raw: assert property (cstb && !dec_byp && !dr.any
		|-> rin.oerr && rin.data == win[7:0]) else $error("bad passthrough");
	a_keep_align: assert property (cstb && !rx_reset_i
		&& cnt_ff == CNT_LAST |=> !rx_realign_o) else $error("needless realign");
	a_realign_pulse: assert property (rx_realign_o |=> !rx_realign_o)
		else $error("realign longer than one cycle");
	a_rx_bound: assert property (rcnt <= 3'(RXD))
		else $error("rx buffer count too large");

	c_overflow: cover property (tx_overflow_o);
	c_realign: cover property (rx_realign_o);
	c_derr: cover property (rx_valid_o && rx_char_o.derr);
	c_skip: cover property (skip);
endmodule // gpcs_top

// *** verif/gpcs_link_model.sv ***
/*
 Far-side model: serializer byte clock, deserializer bit clock and the
 serial receive bit.
 Assumes the block samples both link clocks with its own system clock.
*/
module gpcs_link_model (
	output logic tx_clk_o,
	output logic rx_clk_o,
	output logic rx_bit_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		tx_clk_o = 1'b0;
		rx_clk_o = 1'b0;
		rx_bit_o = 1'b0;
	end
	// ----------------------------------------------------------------
	// Link clocks
	// ----------------------------------------------------------------
	// 200 ns is eight system cycles: locked, no phase drift
	task automatic tx_run(input int n);
		repeat (n) begin
			#100 tx_clk_o = 1'b1;
			#100 tx_clk_o = 1'b0;
		end
	endtask
	// First bit on the line is the top bit; clock stops after a burst
	task automatic rx_send(input logic [9:0] code, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			rx_bit_o = code[i];
			#100 rx_clk_o = 1'b1;
			#100 rx_clk_o = 1'b0;
		end
		// Released line must not look like a held bit
		rx_bit_o = ~rx_bit_o;
	endtask
endmodule // gpcs_link_model

// *** verif/test_gigabit_8b10b_pcs_coding.sv ***
/*
 Self-checking bench of the coding sublayer: registers, TX FIFO and
 encoder, RX aligner and decoder, random traffic among fixed corners.
 Assumes the link model drives both link clocks and the RX serial bit.
*/
module test_gigabit_8b10b_pcs_coding import gpcs_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic tx_reset = 1'b0;
	logic tx_valid = 1'b0;
	gpcs_tx_word_t tx_word = '0;
	logic tx_ready, tx_ovf, tx_unf, tx_kerr, tx_rd, tx_stb;
	logic [9:0] tx_code;
	logic rx_reset = 1'b0;
	logic rx_ready = 1'b0;
	logic rx_bond = 1'b0;
	logic hold_rx = 1'b0;
	logic tx_lclk, rx_lclk, rx_bit, rx_valid, rx_realign, rx_rd;
	gpcs_rx_char_t rx_char;
	int num_errors = 0, n_tests = 0, cyc = 0, n_ovf = 0, n_unf = 0;
	int n_rea = 0;
	logic [9:0] txq [$];
	gpcs_rx_char_t rxq [$];

	initial forever #12.5 clk_sys_i = ~clk_sys_i;

	gpcs_link_model link (.tx_clk_o(tx_lclk), .rx_clk_o(rx_lclk),
		.rx_bit_o(rx_bit));

	gpcs_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(1'b1),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .tx_reset_i(tx_reset),
		.tx_valid_i(tx_valid), .tx_word_i(tx_word), .tx_ready_o(tx_ready),
		.tx_overflow_o(tx_ovf), .tx_underflow_o(tx_unf),
		.tx_control_char_error_o(tx_kerr), .tx_running_disparity_o(tx_rd),
		.tx_link_clk_i(tx_lclk), .tx_code_o(tx_code),
		.tx_code_stb_o(tx_stb), .rx_reset_i(rx_reset),
		.rx_link_clk_i(rx_lclk), .rx_bit_i(rx_bit), .rx_bond_i(rx_bond),
		.rx_char_o(rx_char), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
		.rx_realign_o(rx_realign), .rx_running_disparity_o(rx_rd));

	// ----------------------------------------------------------------
	// Monitors
	// ----------------------------------------------------------------
	always @(posedge clk_sys_i) begin
		rx_ready <= hold_rx ? 1'b0 : 1'($urandom);
		if (tx_stb === 1'b1) txq.push_back(tx_code);
		if (rx_valid === 1'b1 && rx_ready) rxq.push_back(rx_char);
		if (tx_ovf === 1'b1) n_ovf++;
		if (tx_unf === 1'b1) n_unf++;
		if (rx_realign === 1'b1) n_rea++;
	end

	// Hang guard: the whole run needs well under 5000 cycles
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Tasks and expectations
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		// Request stands until pready is seen high at a rising edge
		do @(posedge clk_sys_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic push(input gpcs_tx_word_t w);
		@(posedge clk_sys_i);
		tx_valid <= 1'b1;
		tx_word <= w;
		do @(posedge clk_sys_i); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
	endtask

	task automatic settle(input int n, input bit rx);
		for (int i = 0; i < 400 && (rx ? rxq.size() : txq.size()) < n; i++)
			@(posedge clk_sys_i);
	endtask

	task automatic pulse_reset(input bit rx);
		@(posedge clk_sys_i);
		if (rx) rx_reset <= 1'b1; else tx_reset <= 1'b1;
		@(posedge clk_sys_i);
		rx_reset <= 1'b0;
		tx_reset <= 1'b0;
		@(negedge clk_sys_i);
	endtask

	function automatic logic [9:0] raw_code(input gpcs_tx_lane_t l);
		return {l.mode, l.val, l.data};
	endfunction

	function automatic gpcs_rx_char_t raw_char(input logic [9:0] c);
		gpcs_rx_char_t r;
		r = '0;
		r.k = c[9];
		r.rd = c[8];
		r.data = c[7:0];
		return r;
	endfunction

	task automatic tally_and_finish;
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [31:0] q;
		logic e;
		gpcs_tx_word_t w [4];
		logic [9:0] c [4];
		void'($urandom(32'h0000_e42c));
		repeat (10) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		chk(tx_rd, 0);
		apb(1'b0, A_CTRL, 0, d, e);
		chk(d, 32'(CTRL_RST));
		apb(1'b0, A_PAT0, 0, d, e);
		chk(d, 32'(PAT0_RST));
		apb(1'b1, 8'h40, 32'hFFFF_FFFF, d, e);
		chk(e, 1);
		// Raw words fill the FIFO while the serializer stands still
		apb(1'b1, A_CTRL, 32'h0000_01BA, d, e);
		for (int i = 0; i < 4; i++) begin
			w[i] = 22'($urandom);
			push(w[i]);
		end
		@(negedge clk_sys_i);
		chk(tx_ready, 0);
		@(posedge clk_sys_i);
		tx_valid <= 1'b1;
		@(posedge clk_sys_i);
		tx_valid <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		chk(n_ovf, 1);
		link.tx_run(10);
		repeat (8) @(posedge clk_sys_i);
		chk(txq.size(), 8);
		chk(32'(n_unf > 0), 1);
		for (int i = 0; i < 4; i++) begin
			chk(txq[2 * i], raw_code(w[i].hi));
			chk(txq[2 * i + 1], raw_code(w[i].lo));
		end
		// Comma twice with one polarity, a forced byte, a bad control byte
		apb(1'b1, A_CTRL, 32'h0000_01B8, d, e);
		pulse_reset(1'b0);
		chk(tx_rd, 0);
		txq.delete();
		w[0] = {11'h1BC, 11'h3BC};
		w[1] = {11'h5BC, 11'h100};
		w[2] = {11'h0B5, 11'h0B5};
		for (int i = 0; i < 3; i++) push(w[i]);
		for (int i = 0; i < 3; i++) begin
			link.tx_run(2);
			repeat (6) @(posedge clk_sys_i);
			chk(tx_kerr, 32'(i == 1));
			if (i == 0) chk(tx_rd, 1);
		end
		chk(txq[0], 10'h0FA);
		chk(txq[1], 10'h0FA);
		chk(txq[2], 10'h0FA);
		chk(txq[4], 10'h2AA);
		chk(txq[5], 10'h2AA);
		// FIFO bypass: the word is taken only at a link edge
		apb(1'b1, A_CTRL, 32'h0000_01BB, d, e);
		txq.delete();
		w[3] = 22'($urandom);
		fork
			push(w[3]);
			link.tx_run(2);
		join
		repeat (6) @(posedge clk_sys_i);
		chk(txq.size(), 2);
		chk(txq[0], raw_code(w[3].hi));
		chk(txq[1], raw_code(w[3].lo));
		// Receive: six idle bits give one filler word, then commas
		apb(1'b1, A_CTRL, 32'h0000_01F8, d, e);
		pulse_reset(1'b1);
		link.rx_send(10'h000, 6);
		link.rx_send(10'h0FA, 10);
		chk(rx_rd, 1);
		link.rx_send(10'h0FA, 10);
		link.rx_send(10'h000, 10);
		settle(4, 1'b1);
		chk(rxq.size(), 4);
		chk({rxq[1].k, rxq[1].derr, rxq[1].oerr, rxq[1].comma, rxq[1].data},
			{4'b1001, 8'hBC});
		chk({rxq[2].k, rxq[2].derr, rxq[2].comma, rxq[2].data},
			{3'b111, 8'hBC});
		chk(rxq[3].oerr, 1);
		chk(n_rea, 1);
		// Decoder bypass with random raw characters
		apb(1'b1, A_CTRL, 32'h0000_0004, d, e);
		rxq.delete();
		for (int i = 0; i < 4; i++) begin
			c[i] = 10'($urandom);
			link.rx_send(c[i], 10);
		end
		settle(4, 1'b1);
		chk(rxq.size(), 4);
		for (int i = 0; i < 4; i++)
			chk(32'(rxq[i] & 13'h1EFF), 32'(raw_char(c[i])));
		// Bonding moves the read pointer two words behind the writer
		hold_rx <= 1'b1;
		for (int i = 0; i < 4; i++)
			link.rx_send(c[i], 10);
		apb(1'b0, A_STAT, 0, d, e);
		chk(d[7:2], 6'h20);
		rxq.delete();
		rx_bond <= 1'b1;
		@(posedge clk_sys_i);
		rx_bond <= 1'b0;
		hold_rx <= 1'b0;
		settle(2, 1'b1);
		repeat (20) @(posedge clk_sys_i);
		chk(rxq.size(), 2);
		chk(32'(rxq[0] & 13'h1EFF), 32'(raw_char(c[2])));
		chk(32'(rxq[1] & 13'h1EFF), 32'(raw_char(c[3])));
		// Register write and read back with a random pattern
		d = $urandom;
		apb(1'b1, A_PAT1, d, q, e);
		apb(1'b0, A_PAT1, 0, q, e);
		chk(q, d & 32'h0000_03FF);
		tally_and_finish();
	end
endmodule // test_gigabit_8b10b_pcs_coding
